// ==== odac_defines.vh ====
// Constants for the octal converter serial command port
`ifndef ODAC_DEFINES_VH
`define ODAC_DEFINES_VH
`define ODAC_WORD_BITS 16
`define ODAC_CNT_W 4
`define ODAC_ADDR_HI 13
`define ODAC_ADDR_LO 11
`define ODAC_ADDR_TOP 13
`define ODAC_CTRL_HI 10
`define ODAC_CTRL_LO 8
`define ODAC_DATA_HI 7
`define ODAC_DATA_LO 0
`define ODAC_CH_NUM 8
`define ODAC_CODE_RST 8'h00
`define ODAC_SHDN_RST 8'hff
`define ODAC_CMD_PASS 3'h0
`define ODAC_CMD_CLEAR 3'h1
`define ODAC_CMD_SHDN 3'h2
`define ODAC_CMD_PHASE 3'h3
`define ODAC_CMD_LDALL 3'h4
`define ODAC_CMD_LDIN 3'h5
`define ODAC_CMD_LDBOTH 3'h6
`define ODAC_CMD_XFER 3'h7
`endif

// ==== odac_sync.v ====
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module odac_sync (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [3:0] async_i,
    output reg [3:0] sync_o
);
    reg [3:0] meta_ff;
    // Select, load strobe idle high after reset
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            // Serial clock idles low, so its reset level must be low too
            meta_ff <= 4'ha;
            sync_o <= 4'ha;
        end
        else
        begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end
endmodule // odac_sync
`default_nettype wire

// ==== odac_port.v ====
// Serial command port and register bank of an eight-channel 8-bit converter
//
// Overview of operation
// - Load strobe low copies every input register into its converter register.
// - Shift only with select low; execute the command when select rises.
// - Serial input sampled on each rising serial clock edge.
// - Output changes on falling edge in phase 0, rising edge in phase 1.
// - Reset clears shift logic, input and converter registers to zero.
// - After reset the output phase is mode 0, falling edge.
// - Word is two ignored bits, address, control code, data byte.
// - Shifted bits reappear on the output sixteen clocks later in phase 1, half a clock more in phase 0.
// - Serial output always drives a valid level.
// - Select high ignores clock and input, output holds its value.
// - Each clock receives one bit and sends one bit.
// - Code 000 changes no register at all.
// - Code 001 clears all input and converter registers.
// - Code 010 shuts down channel buffers whose data bit is zero.
// - Code 011 sets phase from the top address bit.
// - Code 100 writes data to all input and converter registers.
// - Code 101 writes data into the addressed input register only.
// - Code 110 writes data into addressed input and converter registers.
// - Code 111 copies all input registers to converter registers.
// - With load strobe low converter registers follow input registers.
// - Clear, load-all and load-both commands leave shutdown.
// - Phase commands also copy input registers to converter registers.
// - Output lags input 16.5 clocks in phase 0, 16 in phase 1.
`timescale 1ns/1ps
`default_nettype none
`include "odac_defines.vh"
module odac_port (
    input wire mclk_i,
    input wire rst_n_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire din_i,
    input wire load_strobe_n_i,
    output reg dout_o,
    output reg [63:0] conv_code_o,
    output reg [63:0] input_code_o,
    output reg [7:0] buf_enable_o,
    output reg phase_mode_o
);
    wire [3:0] pins_sync;
    wire sclk_s;
    wire cs_n_s;
    wire din_s;
    wire ld_n_s;
    reg sclk_d_ff;
    reg cs_n_d_ff;
    reg [15:0] shift_ff;
    reg [15:0] nxt_shift;
    reg phase_ff;
    reg nxt_phase;
    reg [63:0] in_ff;
    reg [63:0] nxt_in;
    reg [63:0] cv_ff;
    reg [63:0] nxt_cv;
    reg [7:0] en_ff;
    reg [7:0] nxt_en;
    reg dout_ff;
    reg nxt_dout;
    reg spill_ff;
    reg nxt_spill;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;
    wire [2:0] cmd_code;
    wire [2:0] cmd_addr;
    wire [7:0] cmd_data;
    integer ch;
    wire ld_n_i_w;

    // Each pin runs off another clock, so all of them pass two flops first
    odac_sync u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({ld_n_i_w, din_i, cs_n_i, sclk_i}),
        .sync_o(pins_sync)
    );
    assign ld_n_i_w = load_strobe_n_i;
    assign sclk_s = pins_sync[0];
    assign cs_n_s = pins_sync[1];
    assign din_s = pins_sync[2];
    assign ld_n_s = pins_sync[3];

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end
        else
        begin
            sclk_d_ff <= sclk_s;
            cs_n_d_ff <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s;
    assign cs_rise = cs_n_s & ~cs_n_d_ff;

    assign cmd_addr = shift_ff[`ODAC_ADDR_HI:`ODAC_ADDR_LO];
    assign cmd_code = shift_ff[`ODAC_CTRL_HI:`ODAC_CTRL_LO];
    assign cmd_data = shift_ff[`ODAC_DATA_HI:`ODAC_DATA_LO];

    function [7:0] chan_get;
        input [63:0] bank;
        input [2:0] idx;
        begin
            chan_get = bank[idx*8 +: 8];
        end
    endfunction

    function [63:0] bank_fill;
        input [7:0] val;
        begin
            bank_fill = {8{val}};
        end
    endfunction

    always @*
    begin
        nxt_shift = shift_ff;
        nxt_dout = dout_ff;
        nxt_spill = spill_ff;
        if (sclk_rise)
        begin
            nxt_shift = {shift_ff[14:0], din_s};
            // Keep the bit leaving the word for the following falling edge
            nxt_spill = shift_ff[15];
        end
        if (sclk_fall && !phase_ff)
        begin
            nxt_dout = spill_ff;
        end
        if (sclk_rise && phase_ff)
        begin
            nxt_dout = shift_ff[15];
        end
    end

    always @*
    begin
        nxt_in = in_ff;
        nxt_cv = cv_ff;
        nxt_en = en_ff;
        nxt_phase = phase_ff;
        if (cs_rise)
        begin
            case (cmd_code)
                `ODAC_CMD_PASS:
                begin
                    nxt_in = in_ff;
                end
                `ODAC_CMD_CLEAR:
                begin
                    nxt_in = bank_fill(`ODAC_CODE_RST);
                    nxt_cv = bank_fill(`ODAC_CODE_RST);
                    nxt_en = `ODAC_SHDN_RST;
                end
                `ODAC_CMD_SHDN:
                begin
                    nxt_en = cmd_data;
                end
                `ODAC_CMD_PHASE:
                begin
                    nxt_phase = shift_ff[`ODAC_ADDR_TOP];
                    nxt_cv = in_ff;
                end
                `ODAC_CMD_LDALL:
                begin
                    nxt_in = bank_fill(cmd_data);
                    nxt_cv = bank_fill(cmd_data);
                    nxt_en = `ODAC_SHDN_RST;
                end
                `ODAC_CMD_LDIN:
                begin
                    nxt_in[cmd_addr*8 +: 8] = cmd_data;
                end
                `ODAC_CMD_LDBOTH:
                begin
                    nxt_in[cmd_addr*8 +: 8] = cmd_data;
                    nxt_cv[cmd_addr*8 +: 8] = cmd_data;
                    nxt_en = `ODAC_SHDN_RST;
                end
                `ODAC_CMD_XFER:
                begin
                    nxt_cv = in_ff;
                end
                default:
                begin
                    nxt_in = in_ff;
                end
            endcase
        end
        // transparent while low, sees updates at once
        if (!ld_n_s)
        begin
            for (ch = 0; ch < `ODAC_CH_NUM; ch = ch + 1)
            begin
                nxt_cv[ch*8 +: 8] = chan_get(nxt_in, ch[2:0]);
            end
        end
    end

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            shift_ff <= 16'h0000;
            in_ff <= 64'h0000000000000000;
            cv_ff <= 64'h0000000000000000;
            en_ff <= `ODAC_SHDN_RST;
            phase_ff <= 1'b0;
            dout_ff <= 1'b0;
            spill_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            spill_ff <= nxt_spill;
            in_ff <= nxt_in;
            cv_ff <= nxt_cv;
            en_ff <= nxt_en;
            phase_ff <= nxt_phase;
            dout_ff <= nxt_dout;
        end
    end

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            dout_o <= 1'b0;
            conv_code_o <= 64'h0000000000000000;
            input_code_o <= 64'h0000000000000000;
            buf_enable_o <= 8'hff;
            phase_mode_o <= 1'b0;
        end
        else
        begin
            dout_o <= nxt_dout;
            conv_code_o <= nxt_cv;
            input_code_o <= nxt_in;
            buf_enable_o <= nxt_en;
            phase_mode_o <= nxt_phase;
        end
    end
endmodule // odac_port
`default_nettype wire

// ==== odac_port_monitor.sv ====
// Port checker for the converter command port
`timescale 1ns/1ps
`default_nettype none
module odac_port_monitor (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic load_strobe_n_i,
    input wire logic dout_o,
    input wire logic [63:0] conv_code_o,
    input wire logic [63:0] input_code_o,
    input wire logic [7:0] buf_enable_o,
    input wire logic phase_mode_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    reset_vals_a: assert property (disable iff (1'b0) !rst_n_i |=>
        conv_code_o == 64'h0 && input_code_o == 64'h0 && !phase_mode_o)
        else $error("reset values wrong");
    // Eight cycles covers the pin synchroniser plus the last output update
    dout_hold_a: assert property (cs_n_i [*8] |-> $stable(dout_o))
        else $error("serial output moved while deselected");
    idle_regs_a: assert property ((cs_n_i && load_strobe_n_i) [*8] |->
        $stable(input_code_o) && $stable(conv_code_o))
        else $error("registers moved while idle");
    shift_regs_a: assert property (!cs_n_i [*6] |-> $stable(input_code_o))
        else $error("input registers moved during shifting");
    transp_a: assert property (!load_strobe_n_i [*4] |-> conv_code_o == input_code_o)
        else $error("converter registers not transparent");
    phase_src_a: assert property ($changed(phase_mode_o) |-> cs_n_i)
        else $error("phase changed while selected");
    shdn_src_a: assert property ($changed(buf_enable_o) |-> cs_n_i)
        else $error("buffer enables changed while selected");
    conv_src_a: assert property ($changed(conv_code_o) |-> cs_n_i || !load_strobe_n_i)
        else $error("converter registers changed without cause");
    cover property ($rose(phase_mode_o));
    cover property (!load_strobe_n_i [*4]);
    cover property ($changed(buf_enable_o));
endmodule // odac_port_monitor
bind odac_port odac_port_monitor u_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .load_strobe_n_i(load_strobe_n_i), .dout_o(dout_o), .conv_code_o(conv_code_o),
    .input_code_o(input_code_o), .buf_enable_o(buf_enable_o), .phase_mode_o(phase_mode_o));
`default_nettype wire

// ==== odac_host.sv ====
// Host serial controller model driving the command port
`timescale 1ns/1ps
`default_nettype none
module odac_host (
    input wire logic mclk_i,
    input wire logic dout_i,
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic din_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] rx);
        int i;
        cs_n_o <= 1'b0;
        din_o <= w[n - 1];
        repeat (5) @(posedge mclk_i);
        for (i = n - 1; i >= 0; i--)
        begin
            sclk_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            sclk_o <= 1'b0;
            // Next bit changes on the falling edge, well clear of the rise
            if (i > 0)
                din_o <= w[i - 1];
            // Output settles three clocks after the pin edge, read one later
            repeat (4) @(posedge mclk_i);
            rx = {rx[14:0], dout_i};
        end
        repeat (2) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        // Released data line must not look like a held bit
        din_o <= ~din_o;
        repeat (16) @(posedge mclk_i);
    endtask
endmodule // odac_host
`default_nettype wire

// ==== odac_port_tb_top.sv ====
// Self-checking testbench for the command port
`timescale 1ns/1ps
`default_nettype none
module odac_port_tb_top;
    logic mclk, rst_n, strobe_n, sclk, cs_n, din, dout, phase;
    logic [63:0] conv, inp;
    logic [7:0] buf_en;
    logic [15:0] rx;
    int err_total, checked;
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    odac_port i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .load_strobe_n_i(strobe_n), .dout_o(dout), .conv_code_o(conv),
        .input_code_o(inp), .buf_enable_o(buf_en), .phase_mode_o(phase));
    odac_host i_host (.mclk_i(mclk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
    task chk(input string n, input logic [63:0] e, input logic [63:0] s);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task send(input logic [15:0] w);
        i_host.xfer({16'h0, w}, 16, rx);
    endtask
    task summarize;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        strobe_n = 1'b1;
        err_total = 0;
        checked = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        chk("inp", 64'h0, inp);
        chk("phase", 64'h0, {63'h0, phase});
        send(16'h3da5);
        chk("inp", 64'ha500_0000_0000_0000, inp);
        chk("conv", 64'h0, conv);
        send(16'h0700);
        chk("conv", 64'ha500_0000_0000_0000, conv);
        i_host.xfer({16'hb5e1, 16'h063c}, 32, rx);
        chk("rx", 64'hb5e1, {48'h0, rx});
        chk("conv", 64'ha500_0000_0000_003c, conv);
        send(16'h2300);
        chk("phase", 64'h1, {63'h0, phase});
        i_host.xfer({16'h5a0f, 16'h0000}, 32, rx);
        chk("rx", 64'h5a0f, {48'h0, rx});
        chk("inp", 64'ha500_0000_0000_003c, inp);
        send(16'h0d99);
        send(16'h0300);
        chk("phase", 64'h0, {63'h0, phase});
        chk("conv", 64'ha500_0000_0000_993c, conv);
        send(16'h020f);
        chk("buf", 64'h0f, {56'h0, buf_en});
        send(16'h0477);
        chk("inp", {8{8'h77}}, inp);
        chk("buf", 64'hff, {56'h0, buf_en});
        send(16'h01ff);
        chk("conv", 64'h0, conv);
        send(16'h0d99);
        strobe_n <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("conv", 64'h9900, conv);
        send(16'h1542);
        chk("conv", 64'h42_9900, conv);
        strobe_n <= 1'b1;
        summarize();
    end
endmodule // odac_port_tb_top
`default_nettype wire
